// File: hdl/esld_encoder_core.sv
`default_nettype none
module esld_encoder_core (
    // clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      srst,
    // register port
    input  wire esld_pkg::esld_reg_req_type reg_req,
    output logic [31:0]                    reg_rdata,
    // configuration bits
    input  wire esld_pkg::esld_config_type cfg,
    // step sources and index
    input  wire esld_pkg::esld_step_type   incr_step,
    input  wire esld_pkg::esld_step_type   bemf_step,
    input  wire logic                      index_event,
    // ramp generator
    input  wire logic [31:0]               ramp_position,
    // observed state
    output logic [31:0]                    encoder_position,
    output logic [31:0]                    ramp_captured_position,
    output logic                           index_flag,
    output logic                           mismatch_flag,
    output logic                           mismatch_now
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [31:0] factor;
        logic [15:0] frac;
        logic [31:0] pos;
        logic [31:0] captured;
        logic [31:0] ramp_captured;
        logic [19:0] limit;
        logic        idx_flag;
        logic        mis_flag;
        logic [31:0] rdata;
    } esld_state_type;

    esld_state_type        st_q;
    esld_state_type        st_d;
    esld_pkg::esld_step_type step_sel;
    logic [31:0]           delta_int;
    logic [17:0]           denom;
    logic [17:0]           frac_up;
    logic [17:0]           frac_dn;
    logic [31:0]           ref_pos;
    logic [32:0]           diff;
    logic [32:0]           abs_diff;
    logic                  mis_cond;
    logic                  wr_flags;
    logic                  wr_factor;
    logic                  wr_limit;

    ////////////////////////////////////////////////////////////////////////////
    assign step_sel  = cfg.source_select ? incr_step : bemf_step;
    assign delta_int = {{16{st_q.factor[31]}}, st_q.factor[31:esld_pkg::FACTOR_INT_LSB]};
    assign denom     = cfg.decimal_mode ? esld_pkg::DENOM_DECIMAL
                                        : esld_pkg::DENOM_BINARY;
    assign frac_up   = {2'b00, st_q.frac} + {2'b00, st_q.factor[15:0]};
    assign frac_dn   = {2'b00, st_q.frac} + denom - {2'b00, st_q.factor[15:0]};
    assign ref_pos   = cfg.source_select ? ramp_position : esld_pkg::RST_ZERO32;
    assign diff      = {st_q.pos[31], st_q.pos} - {ref_pos[31], ref_pos};
    assign abs_diff  = diff[32] ? (33'h0 - diff) : diff;
    // zero limit turns the check off entirely
    assign mis_cond  = (st_q.limit != 20'h0_0000)
                     && (abs_diff > {13'h0000, st_q.limit});
    assign wr_flags  = reg_req.wr && (reg_req.addr == esld_pkg::OFS_EVENT_FLAGS);
    assign wr_factor = reg_req.wr && (reg_req.addr == esld_pkg::OFS_STEP_FACTOR);
    assign wr_limit  = reg_req.wr && (reg_req.addr == esld_pkg::OFS_MISMATCH_LIMIT);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        if (wr_factor) begin
            st_d.factor = reg_req.wdata;
        end
        if (wr_limit) begin
            st_d.limit = reg_req.wdata[esld_pkg::LIMIT_WIDTH-1:0];
        end
        // fraction carries or borrows one whole unit at the denominator
        if (step_sel.step) begin
            if (!step_sel.dir_down) begin
                if (frac_up >= denom) begin
                    st_d.frac = 16'(frac_up - denom);
                    st_d.pos  = st_q.pos + delta_int + 32'h0000_0001;
                end else begin
                    st_d.frac = frac_up[15:0];
                    st_d.pos  = st_q.pos + delta_int;
                end
            end else begin
                if (frac_dn >= denom) begin
                    st_d.frac = 16'(frac_dn - denom);
                    st_d.pos  = st_q.pos - delta_int;
                end else begin
                    st_d.frac = frac_dn[15:0];
                    st_d.pos  = st_q.pos - delta_int - 32'h0000_0001;
                end
            end
        end
        // index wins over a step in the same cycle when clearing
        if (index_event) begin
            st_d.captured = st_q.pos;
            if (cfg.latch_ramp) begin
                st_d.ramp_captured = ramp_position;
            end
            if (cfg.clear_on_index) begin
                st_d.pos  = esld_pkg::RST_ZERO32;
                st_d.frac = 16'h0000;
            end
        end
        // set wins over a write-one clear
        if (wr_flags && reg_req.wdata[esld_pkg::FLAG_INDEX_BIT]) begin
            st_d.idx_flag = 1'b0;
        end
        if (index_event) begin
            st_d.idx_flag = 1'b1;
        end
        if (wr_flags && reg_req.wdata[esld_pkg::FLAG_MISMATCH_BIT]) begin
            st_d.mis_flag = 1'b0;
        end
        if (mis_cond) begin
            st_d.mis_flag = 1'b1;
        end
        case (reg_req.addr)
            esld_pkg::OFS_STEP_FACTOR:    st_d.rdata = st_q.factor;
            esld_pkg::OFS_EVENT_FLAGS:    st_d.rdata = {30'h0000_0000, st_q.mis_flag,
                                                        st_q.idx_flag};
            esld_pkg::OFS_CAPTURED_POS:   st_d.rdata = st_q.captured;
            esld_pkg::OFS_MISMATCH_LIMIT: st_d.rdata = {12'h000, st_q.limit};
            default:                      st_d.rdata = esld_pkg::RST_ZERO32;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_q               <= '0;
            st_q.factor        <= esld_pkg::RST_STEP_FACTOR;
            st_q.limit         <= esld_pkg::RST_MISMATCH_LIMIT;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata              = st_q.rdata;
    assign encoder_position       = st_q.pos;
    assign ramp_captured_position = st_q.ramp_captured;
    assign index_flag             = st_q.idx_flag;
    assign mismatch_flag          = st_q.mis_flag;
    assign mismatch_now           = mis_cond;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_plain_up_step;
        step_sel.step && !step_sel.dir_down && !index_event && !cfg.decimal_mode
            && (st_q.factor[15:0] == 16'h0000);
    endsequence

    sequence s_index_clear;
        index_event && cfg.clear_on_index;
    endsequence

    property p_reset_factor;
        disable iff (1'b0) $past(srst) |-> st_q.factor == 32'h0001_0000;
    endproperty
    a_reset_factor: assert property (p_reset_factor)
        else $error("step factor not one unit after reset");

    property p_step_adds;
        s_plain_up_step ##0 !wr_factor |=> st_q.pos == $past(st_q.pos) + $past(delta_int);
    endproperty
    a_step_adds: assert property (p_step_adds)
        else $error("position did not advance by the factor");

    property p_index_sets;
        index_event |=> index_flag ##1 (index_flag || $past(wr_flags));
    endproperty
    a_index_sets: assert property (p_index_sets)
        else $error("index flag not held");

    property p_index_clear;
        wr_flags && reg_req.wdata[0] && !index_event |=> !index_flag;
    endproperty
    a_index_clear: assert property (p_index_clear)
        else $error("index flag not cleared by write one");

    property p_capture;
        index_event |=> st_q.captured == $past(st_q.pos);
    endproperty
    a_capture: assert property (p_capture)
        else $error("position not captured on index");

    property p_clear_pos;
        s_index_clear |=> encoder_position == 32'h0000_0000;
    endproperty
    a_clear_pos: assert property (p_clear_pos)
        else $error("position not cleared on index");

    property p_ramp_capture;
        index_event && cfg.latch_ramp |=> ramp_captured_position == $past(ramp_position);
    endproperty
    a_ramp_capture: assert property (p_ramp_capture)
        else $error("ramp position not captured");

    property p_mis_sets;
        mis_cond |=> mismatch_flag;
    endproperty
    a_mis_sets: assert property (p_mis_sets)
        else $error("mismatch flag not set");

    property p_mis_hold;
        mis_cond && wr_flags && reg_req.wdata[1] |=> mismatch_flag;
    endproperty
    a_mis_hold: assert property (p_mis_hold)
        else $error("mismatch flag cleared while mismatch persists");

    property p_mis_clear;
        wr_flags && reg_req.wdata[esld_pkg::FLAG_MISMATCH_BIT] && !mis_cond |=> !mismatch_flag;
    endproperty
    a_mis_clear: assert property (p_mis_clear)
        else $error("mismatch flag not cleared by write one");

    property p_zero_limit;
        st_q.limit == 20'h0_0000 && !mismatch_flag |=> !mismatch_flag;
    endproperty
    a_zero_limit: assert property (p_zero_limit)
        else $error("mismatch seen with zero limit");

    property p_bemf_ref;
        !cfg.source_select && st_q.limit != 20'h0_0000 && !st_q.pos[31]
            |-> mis_cond == (st_q.pos > {12'h000, st_q.limit});
    endproperty
    a_bemf_ref: assert property (p_bemf_ref)
        else $error("back-emf mismatch not against zero");
endmodule
`default_nettype wire

// File: common/esld_pkg.sv
`default_nettype none
package esld_pkg;
    // register offsets on the register port
    localparam logic [6:0]  OFS_STEP_FACTOR     = 7'h65;
    localparam logic [6:0]  OFS_EVENT_FLAGS     = 7'h66;
    localparam logic [6:0]  OFS_CAPTURED_POS    = 7'h67;
    localparam logic [6:0]  OFS_MISMATCH_LIMIT  = 7'h68;
    // reset values
    localparam logic [31:0] RST_STEP_FACTOR     = 32'h0001_0000;
    localparam logic [31:0] RST_ZERO32          = 32'h0000_0000;
    localparam logic [19:0] RST_MISMATCH_LIMIT  = 20'h0_0000;
    // field positions
    localparam int          FLAG_INDEX_BIT      = 0;
    localparam int          FLAG_MISMATCH_BIT   = 1;
    localparam int          FACTOR_INT_LSB      = 16;
    localparam int          LIMIT_WIDTH         = 20;
    // fractional denominators
    localparam logic [17:0] DENOM_BINARY        = 18'h1_0000;
    localparam logic [17:0] DENOM_DECIMAL       = 18'h0_2710;

    // encoder configuration bits
    typedef struct packed {
        logic source_select;   // 0: back-emf decoder, 1: incremental encoder
        logic decimal_mode;    // 0: binary fraction, 1: decimal fraction
        logic latch_ramp;      // also capture ramp position on index
        logic clear_on_index;  // clear encoder position after capture
    } esld_config_type;

    // one step request from a step source
    typedef struct packed {
        logic step;
        logic dir_down;
    } esld_step_type;

    // register port request
    typedef struct packed {
        logic        wr;
        logic [6:0]  addr;
        logic [31:0] wdata;
    } esld_reg_req_type;
endpackage
`default_nettype wire

// File: tb/esld_enc_model.sv
`default_nettype none
module esld_enc_model (
    // clock
    input  wire logic                   ref_clk,
    // step sources
    output var esld_pkg::esld_step_type incr_step,
    output var esld_pkg::esld_step_type bemf_step
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        incr_step = '0;
        bemf_step = '0;
    end

    // one step per cycle at most, back to back; src 1 incremental, 0 back-emf
    task automatic send(input int n, input logic dn, input logic src);
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk);
            if (src) incr_step = '{1'b1, dn};
            else bemf_step = '{1'b1, dn};
        end
        @(negedge ref_clk);
        // idle direction flips so a stale level is never mistaken for intent
        incr_step = '{1'b0, ~dn};
        bemf_step = '{1'b0, ~dn};
    endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                      ref_clk;
    logic                      srst;
    esld_pkg::esld_reg_req_type reg_req;
    logic [31:0]               reg_rdata;
    esld_pkg::esld_config_type cfg;
    esld_pkg::esld_step_type   incr_step;
    esld_pkg::esld_step_type   bemf_step;
    logic                      index_event;
    logic [31:0]               ramp_position;
    logic [31:0]               encoder_position;
    logic [31:0]               ramp_captured_position;
    logic                      index_flag;
    logic                      mismatch_flag;
    logic                      mismatch_now;
    int                        failures = 0;
    int                        check_count = 0;

    esld_encoder_core u_esld_encoder_core (.ref_clk(ref_clk), .srst(srst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .cfg(cfg), .incr_step(incr_step), .bemf_step(bemf_step),
        .index_event(index_event), .ramp_position(ramp_position),
        .encoder_position(encoder_position), .ramp_captured_position(ramp_captured_position),
        .index_flag(index_flag), .mismatch_flag(mismatch_flag), .mismatch_now(mismatch_now));
    esld_enc_model u_esld_enc_model (.ref_clk(ref_clk), .incr_step(incr_step),
        .bemf_step(bemf_step));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(negedge ref_clk);
        reg_req = '{1'b1, a, d};
        @(negedge ref_clk);
        reg_req.wr = 1'b0;
    endtask
    // data answers one cycle after the address is taken
    task automatic rd(input logic [6:0] a, input logic [31:0] exp);
        @(negedge ref_clk);
        reg_req.addr = a;
        @(negedge ref_clk);
        chk(reg_rdata, exp);
    endtask
    task automatic stp(input int n, input logic dn, input logic src);
        u_esld_enc_model.send(n, dn, src);
    endtask
    task automatic idx();
        @(negedge ref_clk);
        index_event = 1'b1;
        @(negedge ref_clk);
        index_event = 1'b0;
    endtask
    task automatic results();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(7'h65, 32'h0001_0000);
        rd(7'h66, 32'h0);
        rd(7'h67, 32'h0);
        rd(7'h68, 32'h0);
        rd(7'h00, 32'h0);
    endtask
    task automatic t_scale();
        stp(3, 1'b0, 1'b1);
        chk(encoder_position, 32'h3);
        stp(2, 1'b0, 1'b0);
        chk(encoder_position, 32'h3);
        stp(1, 1'b1, 1'b1);
        chk(encoder_position, 32'h2);
        wr(7'h65, 32'h0000_8000);
        stp(1, 1'b0, 1'b1);
        chk(encoder_position, 32'h2);
        stp(1, 1'b0, 1'b1);
        chk(encoder_position, 32'h3);
        cfg.decimal_mode = 1'b1;
        wr(7'h65, 32'h0000_1388);
        stp(1, 1'b0, 1'b1);
        chk(encoder_position, 32'h3);
        stp(1, 1'b0, 1'b1);
        chk(encoder_position, 32'h4);
        stp(1, 1'b1, 1'b1);
        chk(encoder_position, 32'h3);
        stp(1, 1'b0, 1'b1);
        chk(encoder_position, 32'h4);
        wr(7'h65, 32'hfffe_0000);
        rd(7'h65, 32'hfffe_0000);
        stp(1, 1'b0, 1'b1);
        chk(encoder_position, 32'h2);
        cfg.decimal_mode = 1'b0;
        wr(7'h65, 32'h0001_0000);
    endtask
    task automatic t_index();
        ramp_position = 32'h0000_0123;
        cfg.latch_ramp = 1'b1;
        idx();
        chk(index_flag, 32'h1);
        chk(ramp_captured_position, 32'h123);
        wr(7'h67, 32'h55);
        rd(7'h67, 32'h2);
        rd(7'h66, 32'h1);
        wr(7'h66, 32'h1);
        rd(7'h66, 32'h0);
        cfg.clear_on_index = 1'b1;
        stp(1, 1'b0, 1'b1);
        idx();
        chk(encoder_position, 32'h0);
        rd(7'h67, 32'h3);
        cfg = '{1'b1, 1'b0, 1'b0, 1'b0};
        ramp_position = 32'h0000_0456;
        idx();
        chk(ramp_captured_position, 32'h123);
        wr(7'h66, 32'h1);
    endtask
    task automatic t_mismatch();
        ramp_position = 32'h0;
        wr(7'h68, 32'hfff0_0002);
        rd(7'h68, 32'h2);
        stp(2, 1'b0, 1'b1);
        @(negedge ref_clk);
        chk(mismatch_flag, 32'h0);
        stp(1, 1'b0, 1'b1);
        @(negedge ref_clk);
        chk(mismatch_flag, 32'h1);
        wr(7'h66, 32'h2);
        rd(7'h66, 32'h2);
        ramp_position = 32'h3;
        @(negedge ref_clk);
        chk(mismatch_now, 32'h0);
        wr(7'h66, 32'h2);
        rd(7'h66, 32'h0);
        cfg.source_select = 1'b0;
        @(negedge ref_clk);
        chk(mismatch_now, 32'h1);
        wr(7'h68, 32'h0);
        chk(mismatch_now, 32'h0);
        wr(7'h66, 32'h2);
        stp(5, 1'b0, 1'b0);
        chk(encoder_position, 32'h8);
        rd(7'h66, 32'h0);
    endtask
    // reset in mid-run must restore values that software has changed
    task automatic t_rerun_reset();
        wr(7'h65, 32'h0003_0000);
        wr(7'h68, 32'h5);
        @(negedge ref_clk);
        srst = 1'b1;
        @(negedge ref_clk);
        srst = 1'b0;
        rd(7'h65, 32'h0001_0000);
        rd(7'h68, 32'h0);
        rd(7'h66, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // the whole run needs well under 1000 cycles
    initial begin
        #100us;
        failures++;
        results();
    end
    initial begin
        srst = 1'b1;
        reg_req = '0;
        cfg = '{1'b1, 1'b0, 1'b0, 1'b0};
        index_event = 1'b0;
        ramp_position = 32'h0;
        repeat (10) @(negedge ref_clk);
        srst = 1'b0;
        t_reset();
        t_scale();
        t_index();
        t_mismatch();
        t_rerun_reset();
        results();
    end
endmodule
`default_nettype wire
